/* acso_defines.svh */
`ifndef ACSO_DEFINES_SVH
`define ACSO_DEFINES_SVH

// result word and serial frame lengths in bits
`define ACSO_WORD_W 16
`define ACSO_FRAME_ASYNC 5'h16
`define ACSO_FRAME_SYNC 5'h10

// calibrate strobe must stay high longer than this many cycles
`define ACSO_CAL_HOLD 3'h4
// cycles the ready flag stays high while a word loads
`define ACSO_LOAD_HOLD 3'h4
// length of the calibration run in clock cycles, less one
`define ACSO_CAL_RUN 8'hC8

// self-clocked divider: phase before the high quarter, and the high quarter
`define ACSO_SCLK_PRE 2'h2
`define ACSO_SCLK_HIGH 2'h3

// encodings of the two mode pins standing for the three pin levels
`define ACSO_MODE_PIN_NEG 2'h0
`define ACSO_MODE_PIN_POS 2'h2

// register byte offsets
`define ACSO_REG_STATUS 8'h00
`define ACSO_REG_INT_STAT 8'h04
`define ACSO_REG_INT_MASK 8'h08
`define ACSO_REG_RESULT 8'h0C

// event bit positions in the status and mask registers
`define ACSO_EV_LOADED 0
`define ACSO_EV_SENT 1
`define ACSO_EV_CALDONE 2
`define ACSO_EV_W 3

`endif

/* acso_pkg.sv */
package acso_pkg;
	typedef enum logic [1:0] {ACSO_MODE_ASYNC, ACSO_MODE_EXT, ACSO_MODE_SELF} acso_mode_t;
	typedef enum logic [1:0] {ACSO_CAL_IDLE, ACSO_CAL_HOLD, ACSO_CAL_RESET, ACSO_CAL_RUN} acso_cal_t;
endpackage

/* acso_shift_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface acso_shift_if import acso_pkg::*; ();
	logic start;
	logic abort;
	logic extFall;
	acso_mode_t mode;
	logic [15:0] word;
	logic busy;
	logic done;
	logic sdo;
	logic sdoEn;
	logic sclk;
	logic sclkEn;
	modport ctrl (output start, abort, extFall, mode, word,
		input busy, done, sdo, sdoEn, sclk, sclkEn);
	modport eng (input start, abort, extFall, mode, word,
		output busy, done, sdo, sdoEn, sclk, sclkEn);
endinterface
`default_nettype wire

/* acso_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module acso_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} acso_sync_st_t;

	acso_sync_st_t q;
	acso_sync_st_t d;

	// first stage feeds only the second stage
	always_comb begin
		d.meta = asyncIn;
		d.stable = q.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign syncOut = q.stable;
endmodule
`default_nettype wire

/* acso_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acso_defines.svh"
module acso_shifter import acso_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	acso_shift_if.eng sh
);
	typedef struct packed {
		logic busy;
		logic [21:0] frame;
		logic [4:0] left;
		logic [1:0] phase;
		logic sdo;
		logic sdoEn;
		logic sclk;
		logic sclkEn;
		logic done;
	} acso_shift_st_t;

	acso_shift_st_t q;
	acso_shift_st_t d;
	logic tick;
	logic [21:0] image;

	// frame image, first bit in the top position
	always_comb begin
		if (sh.mode == ACSO_MODE_ASYNC) begin
			image = {1'b0, sh.word[15:8], 2'b11, 1'b0, sh.word[7:0], 2'b11};
		end else begin
			image = {sh.word, 6'h00};
		end
	end

	// next-state logic of the shift engine
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.sclkEn = (sh.mode == ACSO_MODE_SELF);
		tick = 1'b0;
		if (!q.busy) begin
			d.phase = 2'h0;
			d.sclk = 1'b0;
		end else if (sh.mode == ACSO_MODE_SELF) begin
			d.phase = q.phase + 2'h1;
			d.sclk = (q.phase == `ACSO_SCLK_PRE);
			tick = (q.phase == `ACSO_SCLK_HIGH);
		end else begin
			tick = sh.extFall;
			// a mode change mid-frame must not leave the clock stuck high
			d.sclk = 1'b0;
		end
		if (sh.abort) begin
			d.busy = 1'b0;
			d.sdoEn = 1'b0;
			d.sclk = 1'b0;
		end else if (!q.busy && sh.start) begin
			d.busy = 1'b1;
			d.sdoEn = 1'b1;
			d.sdo = image[21];
			d.frame = {image[20:0], 1'b0};
			if (sh.mode == ACSO_MODE_ASYNC) begin
				d.left = `ACSO_FRAME_ASYNC - 5'h1;
			end else begin
				d.left = `ACSO_FRAME_SYNC - 5'h1;
			end
		end else if (q.busy && tick) begin
			if (q.left == 5'h0) begin
				d.busy = 1'b0;
				d.sdoEn = 1'b0;
				d.done = 1'b1;
			end else begin
				d.sdo = q.frame[21];
				d.frame = {q.frame[20:0], 1'b0};
				d.left = q.left - 5'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign sh.busy = q.busy;
	assign sh.done = q.done;
	assign sh.sdo = q.sdo;
	assign sh.sdoEn = q.sdoEn;
	assign sh.sclk = q.sclk;
	assign sh.sclkEn = q.sclkEn;
endmodule
`default_nettype wire

/* acso_ctrl.sv */
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "acso_defines.svh"
module acso_ctrl import acso_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_n,
	input wire logic polarity_select,
	input wire logic [1:0] modeSel,
	input wire logic calibrate_request,
	input wire logic cal_type_sel_a,
	input wire logic cal_type_sel_b,
	input wire logic select_n,
	input wire logic shiftClkIn,
	output logic shiftClkOut,
	output logic shiftClkOe,
	output logic serial_out,
	output logic serialOutEn,
	input wire logic [15:0] resultData,
	input wire logic resultValid,
	output logic data_ready_n,
	output logic lowPower,
	output logic bipolar,
	output logic filterRestart,
	output logic calRunning,
	output logic [1:0] calType,
	output logic irq
);
	typedef struct packed {
		acso_cal_t cal;
		logic [2:0] hiCnt;
		logic [7:0] calCnt;
		logic [1:0] calType;
		logic [15:0] outWord;
		logic wordValid;
		logic [2:0] loadCnt;
		logic extPrev;
		logic [`ACSO_EV_W-1:0] intStat;
		logic [`ACSO_EV_W-1:0] intMask;
		logic irq;
		logic readyN;
		logic lowPower;
		logic bipolar;
		logic restart;
		logic calRun;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} acso_ctrl_st_t;

	acso_ctrl_st_t q;
	acso_ctrl_st_t d;

	logic [5:0] ctlSync;
	logic [1:0] linkSync;
	logic sleepS;
	logic polS;
	logic [1:0] modeS;
	logic calS;
	logic [1:0] typeS;
	logic selS;
	logic clkS;
	acso_mode_t mode;
	logic halted;
	logic [`ACSO_EV_W-1:0] events;
	logic [`ACSO_EV_W-1:0] clrBits;
	logic setupPhase;
	logic wrAccess;
	logic [31:0] statusWord;

	acso_shift_if shIf ();

	// static control pins: slow, two-stage sampling is enough
	acso_sync #(
		.W(6)
	) u_ctl_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.asyncIn({sleep_n, polarity_select, modeSel, cal_type_sel_b, cal_type_sel_a}),
		.syncOut(ctlSync)
	);

	// link pins: shift clock is sampled, its falling edges found below
	acso_sync #(
		.W(2)
	) u_link_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.asyncIn({select_n, shiftClkIn}),
		.syncOut(linkSync)
	);

	// calibrate strobe gets its own pair so its timing is identical everywhere
	acso_sync #(
		.W(1)
	) u_cal_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.asyncIn(calibrate_request),
		.syncOut(calS)
	);

	acso_shifter u_shifter (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.sh(shIf.eng)
	);

	assign sleepS = ctlSync[5];
	assign polS = ctlSync[4];
	assign modeS = ctlSync[3:2];
	assign typeS = ctlSync[1:0];
	assign selS = linkSync[1];
	assign clkS = linkSync[0];

	always_comb begin
		case (modeS)
			`ACSO_MODE_PIN_NEG: mode = ACSO_MODE_ASYNC;
			`ACSO_MODE_PIN_POS: mode = ACSO_MODE_SELF;
			default: mode = ACSO_MODE_EXT;
		endcase
	end

	// anything besides deselect that stops the link: sleep, reset or calibration
	assign halted = q.lowPower || (q.cal == ACSO_CAL_RESET) || (q.cal == ACSO_CAL_RUN);

	// requests to the shift engine
	always_comb begin
		shIf.mode = mode;
		shIf.word = q.outWord;
		shIf.extFall = q.extPrev && !clkS;
		// select starts a frame
		// the done pulse still sees the old valid flag, so it blocks a repeat frame
		shIf.start = !selS && q.wordValid && !halted && !shIf.done;
		shIf.abort = selS || halted;
	end

	assign setupPhase = psel && !penable && !q.pready;
	assign wrAccess = psel && penable && q.pready && pwrite;

	// status view: state of the converter control
	assign statusWord = {22'h00_0000, mode, q.lowPower, q.bipolar, q.calType,
		(q.cal == ACSO_CAL_RESET), q.calRun, shIf.busy, q.wordValid};

	// write-one-to-clear mask for the event register
	always_comb begin
		clrBits = '0;
		if (wrAccess && paddr == `ACSO_REG_INT_STAT) begin
			clrBits = pwdata[`ACSO_EV_W-1:0];
		end
	end

	// main next-state logic
	always_comb begin
		d = q;
		events = '0;
		d.extPrev = clkS;
		d.lowPower = !sleepS;
		d.bipolar = polS;

		// calibration sequencer
		case (q.cal)
			ACSO_CAL_IDLE: begin
				if (calS) begin
					d.calType = typeS;
					d.hiCnt = 3'h1;
					d.cal = ACSO_CAL_HOLD;
				end
			end
			ACSO_CAL_HOLD: begin
				if (!calS) begin
					d.cal = ACSO_CAL_IDLE;
				end else if (q.hiCnt == `ACSO_CAL_HOLD) begin
					d.cal = ACSO_CAL_RESET;
				end else begin
					d.hiCnt = q.hiCnt + 3'h1;
				end
			end
			ACSO_CAL_RESET: begin
				if (!calS) begin
					d.calCnt = `ACSO_CAL_RUN;
					d.cal = ACSO_CAL_RUN;
				end
			end
			ACSO_CAL_RUN: begin
				if (q.calCnt == 8'h00) begin
					d.cal = ACSO_CAL_IDLE;
					events[`ACSO_EV_CALDONE] = 1'b1;
				end else begin
					d.calCnt = q.calCnt - 8'h01;
				end
			end
			default: begin
				d.cal = ACSO_CAL_IDLE;
			end
		endcase
		d.restart = (d.cal == ACSO_CAL_RESET);
		d.calRun = (d.cal == ACSO_CAL_RUN);

		// output register and ready flag
		if (d.restart) begin
			d.wordValid = 1'b0;
			d.loadCnt = 3'h0;
		end else begin
			if (shIf.done) begin
				d.wordValid = 1'b0;
				events[`ACSO_EV_SENT] = 1'b1;
			end
			if (resultValid && !halted) begin
				d.outWord = resultData;
				d.wordValid = 1'b0;
				d.loadCnt = `ACSO_LOAD_HOLD;
			end else if (q.loadCnt != 3'h0) begin
				d.loadCnt = q.loadCnt - 3'h1;
				if (q.loadCnt == 3'h1) begin
					d.wordValid = 1'b1;
					events[`ACSO_EV_LOADED] = 1'b1;
				end
			end
		end
		d.readyN = !d.wordValid;

		// events win over a clear in the same cycle
		d.intStat = (q.intStat & ~clrBits) | events;
		if (wrAccess && paddr == `ACSO_REG_INT_MASK) begin
			d.intMask = pwdata[`ACSO_EV_W-1:0];
		end
		d.irq = |(d.intStat & d.intMask);

		// apb: answer ready in the first access cycle
		d.pready = setupPhase;
		d.pslverr = 1'b0;
		if (setupPhase) begin
			d.prdata = 32'h0000_0000;
			case (paddr)
				`ACSO_REG_STATUS: d.prdata = statusWord;
				`ACSO_REG_INT_STAT: d.prdata = {29'h0000_0000, q.intStat};
				`ACSO_REG_INT_MASK: d.prdata = {29'h0000_0000, q.intMask};
				`ACSO_REG_RESULT: d.prdata = {16'h0000, q.outWord};
				default: d.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.cal <= ACSO_CAL_IDLE;
			q.readyN <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// every port below is a flip-flop
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign data_ready_n = q.readyN;
	assign lowPower = q.lowPower;
	assign bipolar = q.bipolar;
	assign filterRestart = q.restart;
	assign calRunning = q.calRun;
	assign calType = q.calType;
	assign irq = q.irq;
	assign serial_out = shIf.sdo;
	assign serialOutEn = shIf.sdoEn;
	assign shiftClkOut = shIf.sclk;
	assign shiftClkOe = shIf.sclkEn;
endmodule
`default_nettype wire

/* acso_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module acso_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleep_n,
	input wire logic polarity_select,
	input wire logic calibrate_request,
	input wire logic select_n,
	input wire logic shiftClkOut,
	input wire logic shiftClkOe,
	input wire logic serialOutEn,
	input wire logic resultValid,
	input wire logic data_ready_n,
	input wire logic lowPower,
	input wire logic bipolar,
	input wire logic filterRestart,
	input wire logic calRunning
);
	// a frozen enable stretches every count, so checking pauses with it
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst || !ce);

	a_load_hold: assert property (
		resultValid && !lowPower && !filterRestart && !calRunning |-> ##2 data_ready_n [*3])
		else $error("ready flag low while a word loads");
	a_sclk_quarter: assert property (
		$rose(shiftClkOut) |=> !shiftClkOut [*3] ##1 (shiftClkOut || !serialOutEn))
		else $error("shift clock not one high in four");
	a_sclk_dir: assert property (shiftClkOut |-> shiftClkOe)
		else $error("shift clock toggles while pin is an input");
	a_data_release: assert property (select_n [*5] |-> !serialOutEn)
		else $error("data pin driven while deselected");
	a_pready_once: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not a single access cycle");
	a_err_pair: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_cal_reset: assert property (calibrate_request [*8] |-> ##3 filterRestart)
		else $error("long calibrate strobe did not reset");
	a_cal_follows: assert property ($fell(filterRestart) |-> ##[0:2] calRunning)
		else $error("no calibration after reset");
	a_sent_ready: assert property (
		$fell(serialOutEn) && !select_n && !lowPower |-> ##[0:1] data_ready_n)
		else $error("ready flag low after a sent word");
	a_sleep_power: assert property (!sleep_n [*4] |-> lowPower)
		else $error("sleep pin ignored");
	a_range_bipolar: assert property (polarity_select [*5] |-> bipolar)
		else $error("bipolar range not taken");

	c_frame: cover property (!select_n && serialOutEn ##1 !serialOutEn);
	c_calib: cover property ($fell(calRunning));
	c_slverr: cover property (pslverr);
endmodule
bind acso_ctrl acso_properties chk_u (
	.clk(clk),
	.rst(rst),
	.ce(ce),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.sleep_n(sleep_n),
	.polarity_select(polarity_select),
	.calibrate_request(calibrate_request),
	.select_n(select_n),
	.shiftClkOut(shiftClkOut),
	.shiftClkOe(shiftClkOe),
	.serialOutEn(serialOutEn),
	.resultValid(resultValid),
	.data_ready_n(data_ready_n),
	.lowPower(lowPower),
	.bipolar(bipolar),
	.filterRestart(filterRestart),
	.calRunning(calRunning)
);
`default_nettype wire

/* acso_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acso_host_model (
	input wire logic run,
	input wire logic selfMode,
	input wire logic sclkSelf,
	input wire logic sdo,
	input wire logic sdoEn,
	output logic sclkExt,
	output logic [21:0] rxBits,
	output int rxCount
);
	logic sclkSeen;

	initial begin
		sclkExt = 1'b0;
		rxBits = '0;
		rxCount = 0;
	end
	// external clock runs only in frames, idle low
	always begin
		#62.5;
		sclkExt = run && !selfMode && !sclkExt;
	end
	// self mode takes the device clock
	assign sclkSeen = selfMode ? sclkSelf : sclkExt;
	// rising edge samples, first bit lands highest
	always @(posedge sclkSeen) begin
		if (sdoEn) begin
			rxBits <= {rxBits[20:0], sdo};
			rxCount <= rxCount + 1;
		end
	end
endmodule
`default_nettype wire

/* acso_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, e, run;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic sleep_n, polarity_select, calibrate_request, cal_type_sel_a, cal_type_sel_b;
	logic select_n, shiftClkIn, shiftClkOut, shiftClkOe, serial_out, serialOutEn;
	logic [1:0] modeSel, calType;
	logic [15:0] resultData;
	logic resultValid, data_ready_n, lowPower, bipolar, filterRestart, calRunning, irq;
	logic [21:0] rxBits;
	int rxCount, bad_count, check_count;

	acso_ctrl dut_u (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sleep_n(sleep_n),
		.polarity_select(polarity_select),
		.modeSel(modeSel),
		.calibrate_request(calibrate_request),
		.cal_type_sel_a(cal_type_sel_a),
		.cal_type_sel_b(cal_type_sel_b),
		.select_n(select_n),
		.shiftClkIn(shiftClkIn),
		.shiftClkOut(shiftClkOut),
		.shiftClkOe(shiftClkOe),
		.serial_out(serial_out),
		.serialOutEn(serialOutEn),
		.resultData(resultData),
		.resultValid(resultValid),
		.data_ready_n(data_ready_n),
		.lowPower(lowPower),
		.bipolar(bipolar),
		.filterRestart(filterRestart),
		.calRunning(calRunning),
		.calType(calType),
		.irq(irq)
	);
	acso_host_model host_u (
		.run(run),
		.selfMode(modeSel == 2'h2),
		.sclkSelf(shiftClkOut),
		.sdo(serial_out),
		.sdoEn(serialOutEn),
		.sclkExt(shiftClkIn),
		.rxBits(rxBits),
		.rxCount(rxCount)
	);

	// free running system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one bus transfer; leading edge keeps back to back calls apart
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// waits on the frame enable or the calibration flag; a run-out counts
	task automatic waitFor(input bit onCal, input logic v, input int lim);
		int k;
		k = 0;
		while ((onCal ? calRunning : serialOutEn) !== v && k < lim) begin
			@(posedge clk);
			k++;
		end
		if ((onCal ? calRunning : serialOutEn) !== v) begin
			bad_count++;
		end
	endtask

	task automatic load(input logic [15:0] w);
		resultData <= w;
		resultValid <= 1'b1;
		@(posedge clk);
		resultValid <= 1'b0;
		repeat (2) @(posedge clk);
		repeat (3) begin
			chk(data_ready_n, 1'b1);
			@(posedge clk);
		end
		repeat (2) @(posedge clk);
		chk(data_ready_n, 1'b0);
	endtask

	task automatic t_regs();
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'b1, 8'h08, 32'h0000_0002);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(q, 32'h0000_0002);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk({q[30:0], e}, 32'h0000_0001);
		$display("test regs done");
	endtask

	task automatic t_frame(input logic [1:0] m, input logic [15:0] w, input int nb);
		logic [21:0] exp;
		int n0;
		modeSel <= m;
		repeat (5) @(posedge clk);
		chk(shiftClkOe, m == 2'h2);
		load(w);
		chk(irq, 1'b0);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk(q, {16'h0000, w});
		n0 = rxCount;
		select_n <= 1'b0;
		waitFor(1'b0, 1'b1, 20);
		run <= 1'b1;
		waitFor(1'b0, 1'b0, 1000);
		run <= 1'b0;
		select_n <= 1'b1;
		// ready flag and irq settle one edge after the enable drops
		repeat (2) @(posedge clk);
		exp = (nb == 22) ? {1'b0, w[15:8], 2'b11, 1'b0, w[7:0], 2'b11} : {6'h00, w};
		chk(rxCount - n0, nb);
		chk(nb == 22 ? rxBits : {6'h00, rxBits[15:0]}, exp);
		chk(data_ready_n, 1'b1);
		chk(irq, 1'b1);
		apb(1'b1, 8'h04, 32'h0000_0007);
		@(posedge clk);
		chk(irq, 1'b0);
		$display("test frame mode %0d done", m);
	endtask

	task automatic t_abort();
		modeSel <= 2'h1;
		load(16'h0F0F);
		select_n <= 1'b0;
		waitFor(1'b0, 1'b1, 20);
		run <= 1'b1;
		repeat (40) @(posedge clk);
		select_n <= 1'b1;
		run <= 1'b0;
		repeat (6) @(posedge clk);
		chk(serialOutEn, 1'b0);
		chk(data_ready_n, 1'b0);
		chk(irq, 1'b0);
		$display("test abort done");
	endtask

	task automatic t_cal();
		cal_type_sel_b <= 1'b1;
		calibrate_request <= 1'b1;
		repeat (3) @(posedge clk);
		calibrate_request <= 1'b0;
		repeat (10) @(posedge clk);
		chk(filterRestart, 1'b0);
		calibrate_request <= 1'b1;
		repeat (12) @(posedge clk);
		chk(filterRestart, 1'b1);
		chk(data_ready_n, 1'b1);
		calibrate_request <= 1'b0;
		waitFor(1'b1, 1'b1, 20);
		chk(calRunning, 1'b1);
		waitFor(1'b1, 1'b0, 400);
		chk(calType, 2'h2);
		$display("test calibrate done");
	endtask

	task automatic t_pins();
		sleep_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk(lowPower, 1'b1);
		sleep_n <= 1'b1;
		polarity_select <= 1'b1;
		repeat (5) @(posedge clk);
		chk(bipolar, 1'b1);
		chk(lowPower, 1'b0);
		polarity_select <= 1'b0;
		repeat (5) @(posedge clk);
		chk(bipolar, 1'b0);
		$display("test pins done");
	endtask

	// hang guard, far beyond the thousand or so cycles the tests need
	initial begin
		#300000;
		bad_count++;
		print_verdict();
	end

	// reset, then the scenarios in turn
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		sleep_n = 1'b1;
		polarity_select = 1'b0;
		modeSel = 2'h2;
		calibrate_request = 1'b0;
		cal_type_sel_a = 1'b0;
		cal_type_sel_b = 1'b0;
		select_n = 1'b1;
		resultData = 16'h0000;
		resultValid = 1'b0;
		run = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		t_regs();
		t_frame(2'h2, 16'hA53C, 16);
		t_frame(2'h1, 16'h9E01, 16);
		t_frame(2'h0, 16'h5AC3, 22);
		t_abort();
		t_cal();
		t_pins();
		print_verdict();
	end
endmodule
`default_nettype wire
